// File: common/nvsc_pkg.sv
// package of constants and types for the nonvolatile sram host controller
// Contract
// - store sequence: six reads ending 0fc0
// - recall sequence: five reads then 0c63
// - host keeps write enable high during sequence
// - host holds address stable through write
// - host keeps output enable high when writing
// - interleaved access aborts sequence; host avoids it
package nvsc_pkg;
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam int CLK_MHZ = 100;
  // times in ns, us or ms, converted to cycles
  localparam int SETUP_NS = 10;
  localparam int SETUP_CYC = (SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int PULSE_NS = 30;
  localparam int PULSE_CYC = (PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int HOLD_NS = 20;
  localparam int HOLD_CYC = (HOLD_NS * CLK_MHZ + 999) / 1000;
  localparam int BUSY_WAIT_NS = 300;
  localparam int BUSY_WAIT_CYC = (BUSY_WAIT_NS * CLK_MHZ + 999) / 1000;
  localparam int STORE_MS = 10;
  localparam int STORE_CYC = STORE_MS * CLK_MHZ * 1000;
  localparam int RECALL_US = 20;
  localparam int RECALL_CYC = RECALL_US * CLK_MHZ;
  localparam int RESTORE_US = 550;
  localparam int RESTORE_CYC = RESTORE_US * CLK_MHZ;
  localparam int CNT_W = 24;
  localparam int SEQ_LEN = 6;
  localparam logic [ADDR_W-1:0] SEQ_A0 = 15'h0e38;
  localparam logic [ADDR_W-1:0] SEQ_A1 = 15'h31c7;
  localparam logic [ADDR_W-1:0] SEQ_A2 = 15'h03e0;
  localparam logic [ADDR_W-1:0] SEQ_A3 = 15'h3c1f;
  localparam logic [ADDR_W-1:0] SEQ_A4 = 15'h303f;
  localparam logic [ADDR_W-1:0] SEQ_STORE = 15'h0fc0;
  localparam logic [ADDR_W-1:0] SEQ_RECALL = 15'h0c63;

  typedef enum logic [1:0] {NVSC_READ, NVSC_WRITE, NVSC_STORE, NVSC_RECALL} nvsc_cmd_t;

  typedef struct packed {
    nvsc_cmd_t         cmd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } nvsc_req_t;

  typedef struct packed {
    logic              ce_n;
    logic              we_n;
    logic              oe_n;
    logic [ADDR_W-1:0] addr;
  } nvsc_pins_t;
endpackage

// File: logic/nvsc_host.sv
// host controller driving the nonvolatile sram pins
`timescale 1ns/1ps
`default_nettype none
module nvsc_host #(
  parameter int STORE_CYCLES   = nvsc_pkg::STORE_CYC,
  parameter int RECALL_CYCLES  = nvsc_pkg::RECALL_CYC,
  parameter int RESTORE_CYCLES = nvsc_pkg::RESTORE_CYC
) (
  // clock, reset, enable
  input  wire logic                          clk_sys,
  input  wire logic                          nrst,
  input  wire logic                          ce,
  // user command port
  input  wire logic                          req_valid,
  input  wire nvsc_pkg::nvsc_req_t           req,
  output logic                               req_ready,
  output logic                               rsp_valid,
  output logic [nvsc_pkg::DATA_W-1:0]        rsp_data,
  // memory pins
  output nvsc_pkg::nvsc_pins_t               pins,
  input  wire logic [nvsc_pkg::DATA_W-1:0]   io_byte_in,
  output logic [nvsc_pkg::DATA_W-1:0]        io_byte_out,
  output logic                               io_byte_oe,
  input  wire logic                          store_request_busy_n_in,
  output logic                               store_request_busy_n_out,
  output logic                               store_request_busy_n_oe
);
  typedef enum logic [2:0] {S_BOOT, S_IDLE, S_SETUP, S_PULSE, S_HOLD, S_BUSY, S_WAIT}
    nvsc_state_t;

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [nvsc_pkg::DATA_W-1:0] din_s1_reg, din_s2_reg;
  logic                        busy_s1_reg, busy_s2_reg;
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      din_s1_reg  <= '0;
      din_s2_reg  <= '0;
      busy_s1_reg <= 1'b1;
      busy_s2_reg <= 1'b1;
    end else if (ce) begin
      din_s1_reg  <= io_byte_in;
      din_s2_reg  <= din_s1_reg;
      busy_s1_reg <= store_request_busy_n_in;
      busy_s2_reg <= busy_s1_reg;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // sequencer
  nvsc_state_t                 state_reg, state_next;
  logic [nvsc_pkg::CNT_W-1:0]  cnt_reg, cnt_next;
  logic [2:0]                  step_reg, step_next;
  nvsc_pkg::nvsc_req_t         cur_reg, cur_next;
  nvsc_pkg::nvsc_pins_t        pins_reg, pins_next;
  logic [nvsc_pkg::DATA_W-1:0] dout_reg, dout_next, rd_reg, rd_next;
  logic                        doe_reg, doe_next, rdy_reg, rdy_next, rv_reg, rv_next;

  function automatic logic [nvsc_pkg::ADDR_W-1:0] seq_addr(input logic [2:0] s,
                                                          input nvsc_pkg::nvsc_cmd_t c);
    logic [nvsc_pkg::ADDR_W-1:0] a;
    a = nvsc_pkg::SEQ_A0;
    unique case (s)
      3'h0: a = nvsc_pkg::SEQ_A0;
      3'h1: a = nvsc_pkg::SEQ_A1;
      3'h2: a = nvsc_pkg::SEQ_A2;
      3'h3: a = nvsc_pkg::SEQ_A3;
      3'h4: a = nvsc_pkg::SEQ_A4;
      default: a = (c == nvsc_pkg::NVSC_STORE) ? nvsc_pkg::SEQ_STORE
                                               : nvsc_pkg::SEQ_RECALL;
    endcase
    return a;
  endfunction

  logic seq_cmd;
  assign seq_cmd = (cur_reg.cmd == nvsc_pkg::NVSC_STORE) ||
                   (cur_reg.cmd == nvsc_pkg::NVSC_RECALL);

  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    step_next  = step_reg;
    cur_next   = cur_reg;
    pins_next  = pins_reg;
    dout_next  = dout_reg;
    doe_next   = doe_reg;
    rdy_next   = 1'b0;
    rv_next    = 1'b0;
    rd_next    = rd_reg;
    unique case (state_reg)
      S_BOOT: begin
        pins_next = '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, addr: '0};
        if (cnt_reg >= nvsc_pkg::CNT_W'(RESTORE_CYCLES)) begin
          state_next = S_IDLE;
          cnt_next   = '0;
          rdy_next   = 1'b1;
        end else begin
          cnt_next = cnt_reg + 1'b1;
        end
      end
      S_IDLE: begin
        rdy_next = busy_s2_reg;
        if (!busy_s2_reg) begin
          rdy_next = 1'b0;
        end else if (req_valid && rdy_reg) begin
          rdy_next  = 1'b0;
          cur_next  = req;
          step_next = '0;
          cnt_next  = '0;
          state_next = S_SETUP;
          // address stands before any enable falls
          if (req.cmd == nvsc_pkg::NVSC_STORE || req.cmd == nvsc_pkg::NVSC_RECALL) begin
            pins_next.addr = nvsc_pkg::SEQ_A0;
          end else begin
            pins_next.addr = req.addr;
          end
        end
      end
      S_SETUP: begin
        cnt_next = cnt_reg + 1'b1;
        if (cnt_reg + 1'b1 >= nvsc_pkg::CNT_W'(nvsc_pkg::SETUP_CYC)) begin
          cnt_next   = '0;
          state_next = S_PULSE;
          pins_next.ce_n = 1'b0;
          if (cur_reg.cmd == nvsc_pkg::NVSC_WRITE) begin
            pins_next.we_n = 1'b0;
            pins_next.oe_n = 1'b1;
            dout_next = cur_reg.data;
            doe_next  = 1'b1;
          end else begin
            pins_next.we_n = 1'b1;
            pins_next.oe_n = seq_cmd;
          end
        end
      end
      S_PULSE: begin
        cnt_next = cnt_reg + 1'b1;
        if (cnt_reg + 1'b1 >= nvsc_pkg::CNT_W'(nvsc_pkg::PULSE_CYC)) begin
          cnt_next   = '0;
          state_next = S_HOLD;
          if (cur_reg.cmd == nvsc_pkg::NVSC_READ) begin
            rd_next = din_s2_reg;
          end
          pins_next.ce_n = 1'b1;
          pins_next.we_n = 1'b1;
          pins_next.oe_n = 1'b1;
        end
      end
      S_HOLD: begin
        cnt_next = cnt_reg + 1'b1;
        if (cnt_reg + 1'b1 >= nvsc_pkg::CNT_W'(nvsc_pkg::HOLD_CYC)) begin
          cnt_next = '0;
          doe_next = 1'b0;
          if (seq_cmd && step_reg != 3'(nvsc_pkg::SEQ_LEN - 1)) begin
            step_next = step_reg + 1'b1; // no other access between steps
            pins_next.addr = seq_addr(step_reg + 1'b1, cur_reg.cmd);
            state_next = S_SETUP;
          end else if (seq_cmd) begin
            state_next = S_WAIT;
          end else begin
            rv_next    = 1'b1;
            state_next = S_IDLE;
          end
        end
      end
      S_WAIT: begin
        cnt_next = cnt_reg + 1'b1;
        if (!busy_s2_reg) begin
          cnt_next   = '0;
          state_next = S_BUSY;
        end else if (cur_reg.cmd == nvsc_pkg::NVSC_RECALL &&
                     cnt_reg >= nvsc_pkg::CNT_W'(RECALL_CYCLES)) begin
          rv_next    = 1'b1;
          state_next = S_IDLE;
        end else if (cur_reg.cmd == nvsc_pkg::NVSC_STORE &&
                     cnt_reg >= nvsc_pkg::CNT_W'(nvsc_pkg::BUSY_WAIT_CYC)) begin
          rv_next    = 1'b1;
          state_next = S_IDLE;
        end
      end
      S_BUSY: begin
        cnt_next = cnt_reg + 1'b1;
        if (busy_s2_reg || cnt_reg >= nvsc_pkg::CNT_W'(STORE_CYCLES)) begin
          cnt_next   = '0;
          rv_next    = 1'b1;
          state_next = S_IDLE;
        end
      end
      default: state_next = S_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      state_reg <= S_BOOT;
      cnt_reg   <= '0;
      step_reg  <= '0;
      cur_reg   <= '0;
      pins_reg  <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, addr: '0};
      dout_reg  <= '0;
      doe_reg   <= 1'b0;
      rdy_reg   <= 1'b0;
      rv_reg    <= 1'b0;
      rd_reg    <= '0;
    end else if (ce) begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      step_reg  <= step_next;
      cur_reg   <= cur_next;
      pins_reg  <= pins_next;
      dout_reg  <= dout_next;
      doe_reg   <= doe_next;
      rdy_reg   <= rdy_next;
      rv_reg    <= rv_next;
      rd_reg    <= rd_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs
  assign pins        = pins_reg;
  assign io_byte_out = dout_reg;
  assign io_byte_oe  = doe_reg;
  assign req_ready   = rdy_reg;
  assign rsp_valid   = rv_reg;
  assign rsp_data    = rd_reg;
  assign store_request_busy_n_out = 1'b1;
  assign store_request_busy_n_oe  = 1'b0;
endmodule
`default_nettype wire

// File: sim/nvsc_host_sva.sv
// checker of the host pin protocol
`timescale 1ns/1ps
`default_nettype none
module nvsc_host_sva (
  // clock and reset
  input wire logic                 clk_sys,
  input wire logic                 nrst,
  // user side and pins
  input wire logic                 req_valid,
  input wire nvsc_pkg::nvsc_req_t  req,
  input wire logic                 req_ready,
  input wire nvsc_pkg::nvsc_pins_t pins,
  input wire logic                 io_byte_oe
);
  logic [2:0]  cnt_reg, cnt_next;
  logic        rec_reg, rec_next, ceq_reg;
  logic [13:0] exp_a;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // counts chip enable falls of a store or recall sequence
  always_comb begin
    cnt_next = cnt_reg;
    rec_next = rec_reg;
    if (req_valid && req_ready && req.cmd[1]) begin
      cnt_next = 3'h1;
      rec_next = req.cmd[0];
    end else if (cnt_reg != 3'h0 && ceq_reg && !pins.ce_n) begin
      cnt_next = (cnt_reg == 3'h6) ? 3'h0 : cnt_reg + 3'h1;
    end
    case (cnt_reg)
      3'h1: exp_a = 14'h0e38;
      3'h2: exp_a = 14'h31c7;
      3'h3: exp_a = 14'h03e0;
      3'h4: exp_a = 14'h3c1f;
      3'h5: exp_a = 14'h303f;
      default: exp_a = rec_reg ? 14'h0c63 : 14'h0fc0;
    endcase
  end
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      cnt_reg <= 3'h0;
      rec_reg <= 1'b0;
      ceq_reg <= 1'b1;
    end else begin
      cnt_reg <= cnt_next;
      rec_reg <= rec_next;
      ceq_reg <= pins.ce_n;
    end
  end
  ////////////////////////
  a_seq_addr: assert property (
    (cnt_reg != 3'h0 && ceq_reg && !pins.ce_n) |-> pins.we_n && pins.addr[13:0] == exp_a)
    else $error("sequence read wrong");
  a_seq_done: assert property (
    $rose(cnt_reg == 3'h1) |-> ##[1:150] cnt_reg == 3'h0) else $error("sequence stalled");
  a_write_oe_off: assert property (
    !pins.we_n |-> pins.oe_n) else $error("oe low in write");
  a_drive_oe_off: assert property (
    io_byte_oe |-> pins.oe_n) else $error("drive with oe low");
  a_addr_hold: assert property (
    (!pins.ce_n && $past(!pins.ce_n)) |-> $stable(pins.addr)) else $error("addr moved");
  a_addr_setup: assert property (
    $fell(pins.we_n) |-> $stable(pins.addr)) else $error("addr not set");
endmodule
`default_nettype wire

// File: sim/nvsc_mem_model.sv
// behavioural model of the nonvolatile sram
`timescale 1ns/1ps
`default_nettype none
module nvsc_mem_model #(parameter int ST_NS = 1000, parameter int RC_NS = 500) (
  // pins from host, power fail from testbench
  input  wire nvsc_pkg::nvsc_pins_t pins,
  input  wire logic [7:0]           wd,
  input  wire logic                 wd_oe,
  input  wire logic                 pfail,
  // lines and counts
  output logic [7:0]                rd,
  output logic                      busy_n,
  output int                        stores,
  output int                        recalls
);
  logic [7:0] mem [0:32767];
  logic [7:0] nv  [0:32767];
  logic       dirty, act;
  int         step;
  wire        rdy = busy_n && !act;
  wire        wr  = !pins.ce_n && !pins.we_n && rdy;
  wire        drv = !pins.ce_n && !pins.oe_n && pins.we_n && rdy;
  assign rd = drv ? mem[pins.addr] : ~mem[pins.addr];
  task automatic nvop(input logic st);
    step = 0;
    act = 1'b1;
    busy_n = !st;
    if (st) begin
      #(ST_NS) nv = mem;
      stores++;
    end else begin
      #(RC_NS) mem = nv;
      recalls++;
    end
    dirty = 1'b0;
    busy_n = 1'b1;
    act = 1'b0;
  endtask
  function automatic logic [13:0] nxt(input int s);
    case (s)
      0: return 14'h0e38;
      1: return 14'h31c7;
      2: return 14'h03e0;
      3: return 14'h3c1f;
      default: return 14'h303f;
    endcase
  endfunction
  initial begin
    busy_n = 1'b1;
    act = 1'b1;
    step = 0;
    stores = 0;
    recalls = 0;
    #500 mem = nv;
    act = 1'b0;
  end
  always @(negedge wr) begin
    mem[pins.addr] = wd_oe ? wd : ~wd;
    dirty = 1'b1;
  end
  always @(negedge pins.ce_n) if (!act) begin
    if (!pins.we_n) step = 0;
    else if (step == 5 && pins.addr[13:0] == 14'h0fc0) nvop(1'b1);
    else if (step == 5 && pins.addr[13:0] == 14'h0c63) nvop(1'b0);
    else if (step < 5 && pins.addr[13:0] == nxt(step)) step++;
    else step = int'(pins.addr[13:0] == 14'h0e38);
  end
  always @(posedge pfail) begin
    #100 busy_n = 1'b0;
    #1000;
    if (dirty) nvop(1'b1);
    else busy_n = 1'b1;
  end
endmodule
`default_nettype wire

// File: sim/tb_top.sv
// top testbench of the host controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, s) begin total_checks++; if ((s) !== (e)) begin err_count++; \
  $display("FAIL %s exp %h got %h", nm, e, s); end end
module tb_top;
  logic                 clk_sys = 1'b0, nrst = 1'b0, req_valid = 1'b0, pfail = 1'b0;
  logic                 ce_in = 1'b1;
  nvsc_pkg::nvsc_req_t  req = '0;
  nvsc_pkg::nvsc_pins_t pins;
  logic                 req_ready, rsp_valid, io_byte_oe, b_out, b_oe, m_busy_n;
  logic [7:0]           rsp_data, io_byte_in, io_byte_out, q;
  int                   err_count = 0, total_checks = 0, stores, recalls;
  wire                  busy_n = (b_oe ? b_out : 1'b1) & m_busy_n;
  nvsc_host #(.STORE_CYCLES(200), .RECALL_CYCLES(100), .RESTORE_CYCLES(100)) u_dut (
    .clk_sys, .nrst, .ce(ce_in), .req_valid, .req, .req_ready, .rsp_valid, .rsp_data,
    .pins, .io_byte_in, .io_byte_out, .io_byte_oe, .store_request_busy_n_in(busy_n),
    .store_request_busy_n_out(b_out), .store_request_busy_n_oe(b_oe));
  nvsc_mem_model #(.ST_NS(1000), .RC_NS(500)) u_mem (.pins, .wd(io_byte_out),
    .wd_oe(io_byte_oe), .pfail, .rd(io_byte_in), .busy_n(m_busy_n), .stores, .recalls);
  ////////////////////////
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic op(input nvsc_pkg::nvsc_cmd_t c, input logic [14:0] a, input logic [7:0] d);
    int n;
    n = 0;
    req_valid <= 1'b1;
    req <= '{c, a, d};
    do begin @(posedge clk_sys); n++; end while (!(req_ready === 1'b1 && busy_n === 1'b1) && n < 500);
    req_valid <= 1'b0;
    do begin @(posedge clk_sys); n++; end while (rsp_valid !== 1'b1 && n < 900);
    q = rsp_data;
    if (n >= 900) begin err_count++; end_sim(); end
  endtask
  task automatic wb(input logic v);
    int n;
    n = 0;
    while (busy_n !== v && n < 400) begin @(posedge clk_sys); n++; end
    if (n >= 400) begin err_count++; end_sim(); end
  endtask
  task automatic t_pf(input int st);
    pfail <= 1'b1;
    cyc(2);
    pfail <= 1'b0;
    cyc(31);
    `CHK("busy_low", 1'b0, busy_n)
    cyc(20);
    `CHK("ready_busy", 1'b0, req_ready)
    wb(1'b1);
    `CHK("pf_stores", st, stores)
  endtask
  task automatic t_ce();
    ce_in <= 1'b0;
    req_valid <= 1'b1;
    req <= '{nvsc_pkg::NVSC_READ, 15'h1234, 8'h00};
    cyc(8);
    `CHK("ce_addr", 15'h0042, pins.addr)
    `CHK("ce_ready", 1'b1, req_ready)
    ce_in <= 1'b1;
    req_valid <= 1'b0;
    cyc(4);
    `CHK("ce_idle", 1'b1, pins.ce_n)
    $display("clock enable done");
  endtask
  task automatic t_rst();
    nrst <= 1'b0;
    cyc(3);
    nrst <= 1'b1;
    cyc(2);
    `CHK("rst_ce", 1'b1, pins.ce_n)
    `CHK("rst_ready", 1'b0, req_ready)
    cyc(110);
    `CHK("rst_up", 1'b1, req_ready)
    op(nvsc_pkg::NVSC_READ, 15'h0042, 8'h00);
    `CHK("rd_after_rst", 8'h81, q)
    $display("reset done");
  endtask
  ////////////////////////
  initial forever #5 clk_sys = ~clk_sys;
  initial begin
    cyc(16);
    nrst <= 1'b1;
    cyc(50);
    `CHK("ready_boot", 1'b0, req_ready)
    cyc(60);
    `CHK("ready_up", 1'b1, req_ready)
    $display("boot done");
    op(nvsc_pkg::NVSC_WRITE, 15'h1234, 8'ha5);
    op(nvsc_pkg::NVSC_WRITE, 15'h5234, 8'h3c);
    op(nvsc_pkg::NVSC_READ, 15'h1234, 8'h00);
    `CHK("rd_lo", 8'ha5, q)
    op(nvsc_pkg::NVSC_READ, 15'h5234, 8'h00);
    `CHK("rd_hi", 8'h3c, q)
    $display("rw done");
    op(nvsc_pkg::NVSC_STORE, 15'h0000, 8'h00);
    `CHK("store1", 1, stores)
    op(nvsc_pkg::NVSC_STORE, 15'h0000, 8'h00);
    `CHK("store2", 2, stores)
    $display("store done");
    op(nvsc_pkg::NVSC_WRITE, 15'h1234, 8'h77);
    op(nvsc_pkg::NVSC_RECALL, 15'h0000, 8'h00);
    cyc(2);
    `CHK("recalls", 1, recalls)
    op(nvsc_pkg::NVSC_READ, 15'h1234, 8'h00);
    `CHK("rd_recall", 8'ha5, q)
    $display("recall done");
    t_pf(2);
    op(nvsc_pkg::NVSC_WRITE, 15'h0042, 8'h81);
    t_pf(3);
    op(nvsc_pkg::NVSC_READ, 15'h0042, 8'h00);
    `CHK("rd_after_pf", 8'h81, q)
    $display("power fail done");
    t_ce();
    t_rst();
    end_sim();
  end
endmodule
bind nvsc_host nvsc_host_sva u_sva (.clk_sys, .nrst, .req_valid, .req, .req_ready, .pins,
  .io_byte_oe);
`default_nettype wire
